// File: nvsc_defines.vh
`ifndef NVSC_DEFINES_VH
`define NVSC_DEFINES_VH

// bus and counter widths
`define NVSC_AW 9
`define NVSC_DW 8
`define NVSC_CW 18

// clock period in ns
`define NVSC_CLK_NS 40

// times as printed, in their own units
`define NVSC_T_WRITE_PULSE_NS 35
`define NVSC_T_READ_ACCESS_NS 45
`define NVSC_T_STORE_PULSE_NS 250
`define NVSC_T_INHIBIT_US 1
`define NVSC_T_REENABLE_NS 700
`define NVSC_T_STORE_MS 10
`define NVSC_T_RECALL_US 650

// least times and longest times alike round up to whole cycles
`define NVSC_WRITE_CYC ((`NVSC_T_WRITE_PULSE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_READ_CYC ((`NVSC_T_READ_ACCESS_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_PULSE_CYC ((`NVSC_T_STORE_PULSE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_INHIBIT_CYC ((`NVSC_T_INHIBIT_US * 1000 + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_REENABLE_CYC ((`NVSC_T_REENABLE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_STORE_CYC ((`NVSC_T_STORE_MS * 1000000 + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_RECALL_CYC ((`NVSC_T_RECALL_US * 1000 + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)

// synchroniser depth adds to the read sampling point
`define NVSC_SYNC_CYC 2

`endif

// File: nvsc_sync.v
`timescale 1ns/1ps
module nvsc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] d_i,
  output reg [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta;

  // meta feeds only the second stage
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta <= INIT;
      q_o <= INIT;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// File: nvsc_host.v
`timescale 1ns/1ps
`include "nvsc_defines.vh"

// How it works
// - address set in the same cycle the write strobes fall, held until after strobes return high
// - output enable kept high for the whole write
// - write enable held inactive through power-up recall completion
// - store request: line driven low at least 250 ns, then 1 us inhibit
// - optional suppression: host drives store line high actively
module nvsc_host #(
  parameter STORE_CYC = `NVSC_STORE_CYC,
  parameter RECALL_CYC = `NVSC_RECALL_CYC
) (
  input wire REF_CLK_I,
  input wire RST_I,
  input wire REQ_I,
  input wire WRITE_I,
  input wire [`NVSC_AW-1:0] ADDR_I,
  input wire [`NVSC_DW-1:0] WDATA_I,
  input wire STORE_REQ_I,
  input wire SUPPRESS_AUTO_STORE_I,
  input wire [`NVSC_DW-1:0] DQ_I,
  input wire STORE_BUSY_N_I,
  output reg ACK_O,
  output reg [`NVSC_DW-1:0] RDATA_O,
  output reg READY_O,
  output reg STORE_DONE_O,
  output reg DIRTY_O,
  output reg CE_N_O,
  output reg OE_N_O,
  output reg WE_N_O,
  output reg [`NVSC_AW-1:0] ADDR_O,
  output reg [`NVSC_DW-1:0] DQ_O,
  output reg DQ_OE_N_O,
  output reg STORE_BUSY_N_O,
  output reg STORE_BUSY_OE_N_O
);
  localparam [7:0] S_BOOT = 8'h01;
  localparam [7:0] S_IDLE = 8'h02;
  localparam [7:0] S_READ = 8'h04;
  localparam [7:0] S_WRITE = 8'h08;
  localparam [7:0] S_WEND = 8'h10;
  localparam [7:0] S_PULSE = 8'h20;
  localparam [7:0] S_BUSY = 8'h40;
  localparam [7:0] S_REEN = 8'h80;

  function [`NVSC_CW-1:0] cyc;
    input integer n;
    begin
      cyc = n[`NVSC_CW-1:0];
    end
  endfunction

  wire store_busy_s;
  wire [`NVSC_DW-1:0] dq_s;
  reg [7:0] state;
  reg [`NVSC_CW-1:0] cnt;

  nvsc_sync #(.WIDTH(1), .INIT(1'b1)) u_busy_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .d_i(STORE_BUSY_N_I),
    .q_o(store_busy_s)
  );

  nvsc_sync #(.WIDTH(`NVSC_DW), .INIT({`NVSC_DW{1'b0}})) u_dq_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .d_i(DQ_I),
    .q_o(dq_s)
  );

  always @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state <= S_BOOT;
      cnt <= {`NVSC_CW{1'b0}};
      ACK_O <= 1'b0;
      RDATA_O <= {`NVSC_DW{1'b0}};
      READY_O <= 1'b0;
      STORE_DONE_O <= 1'b0;
      DIRTY_O <= 1'b0;
      CE_N_O <= 1'b1;
      OE_N_O <= 1'b1;
      WE_N_O <= 1'b1;
      ADDR_O <= {`NVSC_AW{1'b0}};
      DQ_O <= {`NVSC_DW{1'b0}};
      DQ_OE_N_O <= 1'b1;
      STORE_BUSY_N_O <= 1'b0;
      STORE_BUSY_OE_N_O <= 1'b1;
    end
    else
    begin
      ACK_O <= 1'b0;
      STORE_DONE_O <= 1'b0;
      case (state)
        S_BOOT:
        begin
          // write enable stays high until the recall is surely over
          WE_N_O <= 1'b1;
          if (cnt >= cyc(RECALL_CYC) - 1'b1)
          begin
            cnt <= {`NVSC_CW{1'b0}};
            state <= S_IDLE;
            READY_O <= 1'b1;
          end
          else
            cnt <= cnt + 1'b1;
        end
        S_IDLE:
        begin
          // suppression is an active high drive, not the open-drain release
          STORE_BUSY_N_O <= SUPPRESS_AUTO_STORE_I;
          STORE_BUSY_OE_N_O <= ~SUPPRESS_AUTO_STORE_I;
          if (!store_busy_s && !SUPPRESS_AUTO_STORE_I)
          begin
            // an automatic or ganged store: keep off the bus
            READY_O <= 1'b0;
            cnt <= {`NVSC_CW{1'b0}};
            state <= S_BUSY;
          end
          else if (STORE_REQ_I)
          begin
            READY_O <= 1'b0;
            STORE_BUSY_N_O <= 1'b0;
            STORE_BUSY_OE_N_O <= 1'b0;
            cnt <= {`NVSC_CW{1'b0}};
            state <= S_PULSE;
          end
          else if (REQ_I && WRITE_I)
          begin
            READY_O <= 1'b0;
            ADDR_O <= ADDR_I;
            DQ_O <= WDATA_I;
            DQ_OE_N_O <= 1'b0;
            OE_N_O <= 1'b1;
            CE_N_O <= 1'b0;
            WE_N_O <= 1'b0;
            cnt <= {`NVSC_CW{1'b0}};
            state <= S_WRITE;
          end
          else if (REQ_I)
          begin
            READY_O <= 1'b0;
            ADDR_O <= ADDR_I;
            CE_N_O <= 1'b0;
            OE_N_O <= 1'b0;
            WE_N_O <= 1'b1;
            cnt <= {`NVSC_CW{1'b0}};
            state <= S_READ;
          end
        end
        S_READ:
        begin
          // sample only after access time plus synchroniser latency
          if (cnt >= cyc(`NVSC_READ_CYC + `NVSC_SYNC_CYC) - 1'b1)
          begin
            RDATA_O <= dq_s;
            ACK_O <= 1'b1;
            CE_N_O <= 1'b1;
            OE_N_O <= 1'b1;
            READY_O <= 1'b1;
            state <= S_IDLE;
          end
          else
            cnt <= cnt + 1'b1;
        end
        S_WRITE:
        begin
          if (cnt >= cyc(`NVSC_WRITE_CYC) - 1'b1)
          begin
            // rising strobes capture; address and data held one more cycle
            WE_N_O <= 1'b1;
            CE_N_O <= 1'b1;
            DIRTY_O <= 1'b1;
            state <= S_WEND;
          end
          else
            cnt <= cnt + 1'b1;
        end
        S_WEND:
        begin
          DQ_OE_N_O <= 1'b1;
          ACK_O <= 1'b1;
          READY_O <= 1'b1;
          state <= S_IDLE;
        end
        S_PULSE:
        begin
          // hold every control still over pulse and inhibit delay
          if (cnt >= cyc(`NVSC_PULSE_CYC + `NVSC_INHIBIT_CYC) - 1'b1)
          begin
            STORE_BUSY_N_O <= 1'b1;
            STORE_BUSY_OE_N_O <= 1'b1;
            cnt <= {`NVSC_CW{1'b0}};
            state <= S_BUSY;
          end
          else
            cnt <= cnt + 1'b1;
        end
        S_BUSY:
        begin
          STORE_BUSY_N_O <= 1'b1;
          STORE_BUSY_OE_N_O <= 1'b1;
          // the line may already be high if the device skipped the store
          if (store_busy_s || cnt >= cyc(STORE_CYC) - 1'b1)
          begin
            cnt <= {`NVSC_CW{1'b0}};
            state <= S_REEN;
          end
          else
            cnt <= cnt + 1'b1;
        end
        S_REEN:
        begin
          if (!store_busy_s)
          begin
            cnt <= {`NVSC_CW{1'b0}};
            state <= S_BUSY;
          end
          else if (cnt >= cyc(`NVSC_REENABLE_CYC) - 1'b1)
          begin
            DIRTY_O <= 1'b0;
            STORE_DONE_O <= 1'b1;
            READY_O <= 1'b1;
            state <= S_IDLE;
          end
          else
            cnt <= cnt + 1'b1;
        end
        default:
        begin
          state <= S_BOOT;
          cnt <= {`NVSC_CW{1'b0}};
          READY_O <= 1'b0;
        end
      endcase
    end
  end
endmodule

// File: nvsc_host_assertions.sv
`timescale 1ns/1ps
module nvsc_host_assertions (
  input wire REF_CLK_I,
  input wire RST_I,
  input wire READY_O,
  input wire STORE_DONE_O,
  input wire DIRTY_O,
  input wire CE_N_O,
  input wire OE_N_O,
  input wire WE_N_O,
  input wire [8:0] ADDR_O,
  input wire DQ_OE_N_O,
  input wire STORE_BUSY_N_O,
  input wire STORE_BUSY_OE_N_O,
  input wire STORE_BUSY_N_I
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  sequence pull_low;
    !STORE_BUSY_OE_N_O && !STORE_BUSY_N_O;
  endsequence
  sequence store_pulse;
    pull_low [*8];
  endsequence
  chk_read_strobes: assert property (!OE_N_O |-> !CE_N_O && WE_N_O)
    else $error("read strobes");
  chk_write_oe_high: assert property (!WE_N_O |-> OE_N_O && !CE_N_O && !DQ_OE_N_O)
    else $error("write strobes");
  chk_addr_hold: assert property ($fell(WE_N_O) |=> $stable(ADDR_O) && CE_N_O)
    else $error("write address");
  chk_no_write_store: assert property (pull_low |-> WE_N_O && DQ_OE_N_O)
    else $error("write in store");
  chk_store_pulse: assert property (
    $fell(STORE_BUSY_OE_N_O || STORE_BUSY_N_O) |-> store_pulse)
    else $error("store pulse");
  chk_inhibit_still: assert property (
    pull_low |-> $stable({CE_N_O, OE_N_O, WE_N_O, ADDR_O}))
    else $error("bus moved in inhibit");
  chk_busy_ready: assert property (!STORE_BUSY_N_I [*5] |-> !READY_O)
    else $error("ready in busy");
  chk_reenable_wait: assert property (
    STORE_DONE_O |-> $past(STORE_BUSY_N_I, 16) && READY_O)
    else $error("early reenable");
  chk_store_dirty: assert property (STORE_DONE_O |-> !DIRTY_O)
    else $error("dirty after store");
endmodule

// File: nvsc_dev_model.sv
`timescale 1ns/1ps
module nvsc_dev_model (
  input wire ce_n_i,
  input wire oe_n_i,
  input wire we_n_i,
  input wire [8:0] addr_i,
  input wire [7:0] dq_host_i,
  input wire dq_oe_n_i,
  input wire busy_host_i,
  input wire busy_oe_n_i,
  input wire supply_ok_i,
  output wire [7:0] dq_o,
  output wire store_busy_n_o
);
  reg [7:0] mem [0:511];
  reg [7:0] shadow [0:511];
  reg [7:0] last = 8'h00;
  reg [7:0] wdat = 8'h00;
  reg [8:0] wadr = 9'h000;
  reg dirty = 1'b0;
  reg pull = 1'b0;
  // storage capacitor taken as charged for the whole run
  reg cap_ok = 1'b1;
  integer stores = 0;
  integer j;
  integer k;
  // a strong host drive beats the weak pull-down; undriven line idles high
  assign store_busy_n_o = !busy_oe_n_i ? busy_host_i : !pull;
  wire rd = !ce_n_i && !oe_n_i && we_n_i && store_busy_n_o;
  wire wr = !ce_n_i && !we_n_i && store_busy_n_o;
  // power-up recall: wipe the array, then load the shadow copy
  // the shadow starts as each address's low byte, so a read shows the recall
  initial
  begin
    for (j = 0; j < 512; j = j + 1)
    begin
      shadow[j] = j[7:0];
      mem[j] = 8'h00;
    end
    for (j = 0; j < 512; j = j + 1)
      mem[j] = shadow[j];
  end
  assign dq_o = !dq_oe_n_i ? dq_host_i : rd ? mem[addr_i] : ~last;
  always @(rd or addr_i)
    if (rd)
      last = mem[addr_i];
  always @*
    if (wr)
    begin
      wadr = addr_i;
      wdat = dq_o;
    end
  // a store line drop ends the write without storing it
  always @(negedge wr)
    if (store_busy_n_o)
    begin
      mem[wadr] = wdat;
      dirty = 1'b1;
    end
  task do_store;
    begin
      pull = 1'b1;
      // snapshot at the start, so a supply change mid-store cannot tear it
      for (k = 0; k < 512; k = k + 1)
        shadow[k] = mem[k];
      #800;
      stores = stores + 1;
      dirty = 1'b0;
      pull = 1'b0;
    end
  endtask
  always @(negedge store_busy_n_o)
    if (!pull)
    begin
      #1000;
      if (dirty && cap_ok)
        do_store;
    end
  always @(negedge supply_ok_i)
    if (dirty)
    begin
      pull = 1'b1;
      #50;
      if (store_busy_n_o)
        pull = 1'b0;
      else
        do_store;
    end
endmodule

// File: nvsc_host_test.sv
`timescale 1ns/1ps
module nvsc_host_test;
  reg clk = 0, rst = 1, req = 0, w = 0, sreq = 0, supp = 0, sup = 1;
  reg [8:0] a = 9'h000;
  reg [7:0] d = 8'h00;
  wire ack, rdy, done, dirty, ce, oe, we, dqoe, busyo, busyoe, busy;
  wire [8:0] ao;
  wire [7:0] rdata, dqo, dq;
  integer num_errors = 0, num_checks = 0, s;
  always #20 clk = ~clk;
  nvsc_host #(.STORE_CYC(50), .RECALL_CYC(20)) u_dut (.REF_CLK_I(clk), .RST_I(rst),
    .REQ_I(req), .WRITE_I(w), .ADDR_I(a), .WDATA_I(d), .STORE_REQ_I(sreq),
    .SUPPRESS_AUTO_STORE_I(supp), .DQ_I(dq), .STORE_BUSY_N_I(busy), .ACK_O(ack),
    .RDATA_O(rdata), .READY_O(rdy), .STORE_DONE_O(done), .DIRTY_O(dirty), .CE_N_O(ce),
    .OE_N_O(oe), .WE_N_O(we), .ADDR_O(ao), .DQ_O(dqo), .DQ_OE_N_O(dqoe),
    .STORE_BUSY_N_O(busyo), .STORE_BUSY_OE_N_O(busyoe));
  nvsc_dev_model u_dev (.ce_n_i(ce), .oe_n_i(oe), .we_n_i(we), .addr_i(ao),
    .dq_host_i(dqo), .dq_oe_n_i(dqoe), .busy_host_i(busyo), .busy_oe_n_i(busyoe),
    .supply_ok_i(sup), .dq_o(dq), .store_busy_n_o(busy));
  task finish_test;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        $display("BAD %0t got %h exp %h", $time, got, exp);
        num_errors = num_errors + 1;
      end
    end
  endtask
  task wt(input integer k, input v);
    integer i;
    begin
      i = 0;
      while ((k == 0 ? ack : k == 1 ? done : rdy) !== v)
      begin
        if (i == 400)
        begin
          num_errors = num_errors + 1;
          finish_test;
        end
        @(posedge clk);
        #1;
        i = i + 1;
      end
    end
  endtask
  task acc(input wr, input [8:0] ad, input [7:0] dat);
    begin
      @(negedge clk);
      req = 1;
      w = wr;
      a = ad;
      d = dat;
      wt(0, 1);
      @(negedge clk);
      req = 0;
    end
  endtask
  task store_wait;
    begin
      wt(2, 0);
      @(negedge clk);
      sreq = 0;
      sup = 1;
      wt(1, 1);
      chk(dirty, 0);
      // callers drive their next inputs on the falling edge
      @(negedge clk);
    end
  endtask
  // recalled contents first, then both ends of the array, back to back
  task t_rw;
    begin
      acc(0, 9'h123, 8'h00);
      chk(rdata, 8'h23);
      acc(1, 9'h000, 8'hA5);
      acc(1, 9'h1FF, 8'h3C);
      chk(dirty, 1);
      acc(0, 9'h1FF, 8'h00);
      chk(rdata, 8'h3C);
      acc(0, 9'h000, 8'h00);
      chk(rdata, 8'hA5);
    end
  endtask
  task t_store;
    begin
      s = u_dev.stores;
      sreq = 1;
      store_wait;
      chk(u_dev.stores, s + 1);
      sreq = 1;
      store_wait;
      chk(u_dev.stores, s + 1);
      acc(0, 9'h1FF, 8'h00);
      chk(rdata, 8'h3C);
    end
  endtask
  task t_auto;
    begin
      acc(1, 9'h055, 8'h81);
      s = u_dev.stores;
      sup = 0;
      store_wait;
      chk(u_dev.stores, s + 1);
      acc(1, 9'h0AA, 8'h7E);
      supp = 1;
      repeat (4) @(negedge clk);
      sup = 0;
      repeat (60) @(negedge clk);
      chk(u_dev.stores, s + 1);
      chk(rdy, 1);
      sup = 1;
      supp = 0;
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 0;
    wt(2, 1);
    t_rw;
    t_store;
    t_auto;
    finish_test;
  end
endmodule
bind nvsc_host nvsc_host_assertions u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .READY_O(READY_O), .STORE_DONE_O(STORE_DONE_O), .DIRTY_O(DIRTY_O), .CE_N_O(CE_N_O),
  .OE_N_O(OE_N_O), .WE_N_O(WE_N_O), .ADDR_O(ADDR_O), .DQ_OE_N_O(DQ_OE_N_O),
  .STORE_BUSY_N_O(STORE_BUSY_N_O), .STORE_BUSY_OE_N_O(STORE_BUSY_OE_N_O),
  .STORE_BUSY_N_I(STORE_BUSY_N_I));
